// file: hw/input_terminal_function_decoder.sv
// Purpose: polarity correction, function routing and multispeed selection for the input terminals
// Assumes: terminal levels synchronous to clock_i, high meaning contact closed
// Notes: settings live in AXI4-Lite registers; function outputs lag the pins by two cycles, the binary speed index by four plus the settle delay
`timescale 1ns/1ps
// Behaviour
// RL1: codes 56 to 63 route a terminal to user sequence inputs one to eight.
// RL2: code 74 drives pulse counter count input, code 75 its clear.
// RL3: codes 66 to 68 select stored position bits; 73 switches speed/position.
// RL4: in absolute position mode, 69 is home limit, 70 home trigger.
// RL5: code 71 inhibits forward drive, code 72 inhibits reverse drive.
// RL6: code 65 holds the analog frequency command while asserted.
// RL7: code 53 clears the accumulated input energy value while asserted.
// RL8: code 52 permits the torque command input.
// RL9: code 51 forces terminal operation for run and frequency commands.
// RL10: normally-open reads active when closed; normally-closed active when open.
// RL11: each of nine terminals has polarity, 00 normally-open, 01 normally-closed.
// RL12: a terminal with the reset function is always normally-open.
// RL13: mode 00 selects binary selection over four inputs, sixteen speeds.
// RL14: mode 01 selects bit selection over seven inputs, eight speeds.
// RL15: speed frequency is zero or clamped between start and maximum frequency.
// RL16: terminal source with reversible analog reverses direction when sum below zero.
// RL17: binary codes 02 to 05 form the index, first select least significant.
// RL18: bit mode codes 32 to 38, lowest active wins, none means zero.
// RL19: binary index accepted only after inputs stable for the settle delay.
// RL20: levels sampled on the clock, polarity applied before decoding.
module input_terminal_function_decoder
  import term_decode_pkg::*;
#(
  parameter int SETTLE_W = 16
) (
  // system
  input wire logic clock_i,
  input wire logic reset_i,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // terminal pins and auxiliary frequency
  input wire logic [NUM_TERM-1:0] terminal_i,
  input wire logic forward_terminal_i,
  input wire logic signed [FREQ_W-1:0] aux_freq_i,
  // decoded functions
  output logic [NUM_TERM-1:0] user_seq_input_o,
  output logic count_pulse_in_o,
  output logic count_clear_in_o,
  output logic [2:0] pos_select_o,
  output logic speed_position_switch_o,
  output logic home_limit_in_o,
  output logic home_trigger_in_o,
  output logic fwd_drive_inhibit_o,
  output logic rev_drive_inhibit_o,
  output logic analog_cmd_hold_o,
  output logic energy_total_clear_o,
  output logic torque_cmd_permit_o,
  output logic force_terminal_op_o,
  output logic fault_reset_in_o,
  output logic forward_run_in_o,
  // speed selection
  output logic [3:0] speed_index_o,
  output logic [FREQ_W-1:0] speed_freq_o,
  output logic direction_reverse_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  function automatic logic fn_active(input logic [7:0] code, input logic [63:0] funcs,
                                     input logic [NUM_TERM-1:0] lv);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (funcs[8*i +: 8] == code && lv[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return a[1:0] == 2'h0 && (a <= REG_STATUS || (a >= REG_SPEED_BASE && a <= REG_SPEED_LAST));
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // settings
  logic [31:0] ctrl_cfg, pol_cfg, settle_cfg, limits_cfg;
  logic [63:0] func_cfg;
  logic [FREQ_W-1:0] speed_freq [NUM_SPEED];
  logic [31:0] next_ctrl, next_pol, next_settle, next_limits;
  logic [63:0] next_func;
  logic [FREQ_W-1:0] next_speed_freq [NUM_SPEED];
  // bus
  logic wr_fire, rd_fire;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, status_word;

  assign wr_fire = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
  assign s_axi_awready_o = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
  assign s_axi_wready_o = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
  assign rd_fire = s_axi_arvalid_i && !s_axi_rvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_comb begin
    next_ctrl = ctrl_cfg;
    next_pol = pol_cfg;
    next_settle = settle_cfg;
    next_limits = limits_cfg;
    next_func = func_cfg;
    next_speed_freq = speed_freq;
    next_bvalid = s_axi_bvalid_o && !s_axi_bready_i;
    next_bresp = s_axi_bresp_o;
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = addr_mapped(s_axi_awaddr_i) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_awaddr_i)
        REG_CTRL: next_ctrl = apply_strb(ctrl_cfg, s_axi_wdata_i, s_axi_wstrb_i) & CTRL_MASK;
        REG_POL: next_pol = apply_strb(pol_cfg, s_axi_wdata_i, s_axi_wstrb_i) & POL_MASK;
        REG_FUNC_LO: next_func[31:0] = apply_strb(func_cfg[31:0], s_axi_wdata_i, s_axi_wstrb_i);
        REG_FUNC_HI: next_func[63:32] = apply_strb(func_cfg[63:32], s_axi_wdata_i, s_axi_wstrb_i);
        REG_SETTLE: next_settle = apply_strb(settle_cfg, s_axi_wdata_i, s_axi_wstrb_i) & SETTLE_MASK;
        REG_LIMITS: next_limits = apply_strb(limits_cfg, s_axi_wdata_i, s_axi_wstrb_i);
        default: begin
          if (addr_mapped(s_axi_awaddr_i) && s_axi_awaddr_i >= REG_SPEED_BASE) begin
            next_speed_freq[s_axi_awaddr_i[5:2]] = FREQ_W'(apply_strb(
              {16'h0000, speed_freq[s_axi_awaddr_i[5:2]]}, s_axi_wdata_i, s_axi_wstrb_i) & SPEED_MASK);
          end
        end
      endcase
    end
  end

  always_comb begin
    next_rvalid = s_axi_rvalid_o && !s_axi_rready_i;
    next_rdata = s_axi_rdata_o;
    next_rresp = s_axi_rresp_o;
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr_i)
        REG_CTRL: next_rdata = ctrl_cfg;
        REG_POL: next_rdata = pol_cfg;
        REG_FUNC_LO: next_rdata = func_cfg[31:0];
        REG_FUNC_HI: next_rdata = func_cfg[63:32];
        REG_SETTLE: next_rdata = settle_cfg;
        REG_LIMITS: next_rdata = limits_cfg;
        REG_STATUS: next_rdata = status_word;
        default: begin
          next_rdata = 32'h0000_0000;
          if (addr_mapped(s_axi_araddr_i)) begin
            next_rdata = {16'h0000, speed_freq[s_axi_araddr_i[5:2]]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_cfg <= CTRL_RST;
      pol_cfg <= POL_RST;
      settle_cfg <= SETTLE_RST;
      limits_cfg <= LIMITS_RST;
      func_cfg <= FUNC_RST;
      speed_freq <= '{default: '0};
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RESP_OKAY;
    end else begin
      ctrl_cfg <= next_ctrl;
      pol_cfg <= next_pol;
      settle_cfg <= next_settle;
      limits_cfg <= next_limits;
      func_cfg <= next_func;
      speed_freq <= next_speed_freq;
      s_axi_bvalid_o <= next_bvalid;
      s_axi_bresp_o <= next_bresp;
      s_axi_rvalid_o <= next_rvalid;
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= next_rresp;
    end
  end

  // terminal sampling and polarity
  logic [NUM_TERM:0] term_raw;
  logic [NUM_TERM-1:0] level;
  logic [NUM_TERM-1:0] reset_mask;
  logic fwd_level;
  logic [3:0] bin_idx, settled_idx, onehot_idx, next_index;
  logic [NUM_ONEHOT-1:0] onehot_sel;
  logic [FREQ_W-1:0] start_freq, max_freq, raw_freq, next_freq;
  logic signed [FREQ_W+1:0] freq_sum;
  logic next_reverse;
  logic [1:0] ms_mode;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      term_raw <= '0;
    end else begin
      term_raw <= {forward_terminal_i, terminal_i}; // RL20
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_TERM; i++) begin
      reset_mask[i] = func_cfg[8*i +: 8] == FN_FAULT_RESET;
      // reset-assigned terminal ignores its polarity setting
      level[i] = term_raw[i] ^ (pol_cfg[2*i +: 2] == POL_NC && !reset_mask[i]); // RL10 RL11 RL12
    end
    fwd_level = term_raw[NUM_TERM] ^ (pol_cfg[2*NUM_TERM +: 2] == POL_NC); // RL10 RL11
  end

  assign ms_mode = ctrl_cfg[CTRL_MODE_LSB +: 2];
  assign start_freq = limits_cfg[FREQ_W-1:0];
  assign max_freq = limits_cfg[LIM_MAX_LSB +: FREQ_W];

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      bin_idx[k] = fn_active(8'(FN_BIN_SEL0 + k), func_cfg, level); // RL17
    end
    for (int k = 0; k < NUM_ONEHOT; k++) begin
      onehot_sel[k] = fn_active(8'(FN_ONEHOT_SEL1 + k), func_cfg, level);
    end
    onehot_idx = 4'h0;
    for (int k = NUM_ONEHOT - 1; k >= 0; k--) begin
      if (onehot_sel[k]) begin
        onehot_idx = 4'(k + 1); // RL18
      end
    end
  end

  select_settle #(.IDX_W(4), .SETTLE_W(SETTLE_W)) u_settle (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .sample_i(bin_idx),
    .delay_i(settle_cfg[SETTLE_W-1:0]), // RL19
    .settled_o(settled_idx)
  );

  always_comb begin
    // bit mode is not debounced; only binary combinations can glitch through codes
    next_index = (ms_mode == MS_BIT) ? onehot_idx : settled_idx; // RL13 RL14
    raw_freq = speed_freq[next_index];
    next_freq = raw_freq;
    if (raw_freq != '0 && raw_freq < start_freq) begin
      next_freq = start_freq; // RL15
    end
    if (raw_freq > max_freq) begin
      next_freq = max_freq; // RL15
    end
    freq_sum = $signed({2'b00, next_freq}) + (FREQ_W+2)'(aux_freq_i);
    next_reverse = ctrl_cfg[CTRL_FSRC_LSB +: 2] == FSRC_TERMINAL && ctrl_cfg[CTRL_REVERSIBLE_BIT]
                   && freq_sum < 0; // RL16
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[NUM_TERM:0] = {fwd_level, level};
    status_word[STAT_INDEX_LSB +: 4] = speed_index_o;
    status_word[STAT_REVERSE_BIT] = direction_reverse_o;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      user_seq_input_o <= '0;
      count_pulse_in_o <= 1'b0;
      count_clear_in_o <= 1'b0;
      pos_select_o <= 3'h0;
      speed_position_switch_o <= 1'b0;
      home_limit_in_o <= 1'b0;
      home_trigger_in_o <= 1'b0;
      fwd_drive_inhibit_o <= 1'b0;
      rev_drive_inhibit_o <= 1'b0;
      analog_cmd_hold_o <= 1'b0;
      energy_total_clear_o <= 1'b0;
      torque_cmd_permit_o <= 1'b0;
      force_terminal_op_o <= 1'b0;
      fault_reset_in_o <= 1'b0;
      forward_run_in_o <= 1'b0;
      speed_index_o <= 4'h0;
      speed_freq_o <= '0;
      direction_reverse_o <= 1'b0;
    end else begin
      for (int k = 0; k < NUM_TERM; k++) begin
        user_seq_input_o[k] <= fn_active(8'(FN_USER_SEQ1 + k), func_cfg, level); // RL1
      end
      count_pulse_in_o <= fn_active(FN_COUNT_PULSE, func_cfg, level); // RL2
      count_clear_in_o <= fn_active(FN_COUNT_CLEAR, func_cfg, level); // RL2
      for (int k = 0; k < 3; k++) begin
        pos_select_o[k] <= fn_active(8'(FN_POS_SEL0 + k), func_cfg, level); // RL3
      end
      speed_position_switch_o <= fn_active(FN_SPEED_POS, func_cfg, level); // RL3
      home_limit_in_o <= ctrl_cfg[CTRL_ABSPOS_BIT] && fn_active(FN_HOME_LIMIT, func_cfg, level); // RL4
      home_trigger_in_o <= ctrl_cfg[CTRL_ABSPOS_BIT] && fn_active(FN_HOME_TRIGGER, func_cfg, level); // RL4
      fwd_drive_inhibit_o <= fn_active(FN_FWD_INHIBIT, func_cfg, level); // RL5
      rev_drive_inhibit_o <= fn_active(FN_REV_INHIBIT, func_cfg, level); // RL5
      analog_cmd_hold_o <= fn_active(FN_ANALOG_HOLD, func_cfg, level); // RL6
      energy_total_clear_o <= fn_active(FN_ENERGY_CLEAR, func_cfg, level); // RL7
      torque_cmd_permit_o <= fn_active(FN_TORQUE_PERMIT, func_cfg, level); // RL8
      force_terminal_op_o <= fn_active(FN_FORCE_TERM, func_cfg, level); // RL9
      fault_reset_in_o <= fn_active(FN_FAULT_RESET, func_cfg, level);
      forward_run_in_o <= fwd_level;
      speed_index_o <= next_index;
      speed_freq_o <= next_freq;
      direction_reverse_o <= next_reverse;
    end
  end

  property p_fwd_polarity;
    ##1 forward_run_in_o == ($past(term_raw[NUM_TERM]) ^ ($past(pol_cfg[2*NUM_TERM +: 2]) == POL_NC));
  endproperty
  a_fwd_polarity: assert property (p_fwd_polarity) else $error("forward polarity wrong"); // RL11
  property p_reset_no;
    ##1 fault_reset_in_o == $past(|(term_raw[NUM_TERM-1:0] & reset_mask));
  endproperty
  a_reset_no: assert property (p_reset_no) else $error("reset terminal not normally-open"); // RL12
  property p_bit_first;
    (ms_mode == MS_BIT && onehot_sel[0]) |=> speed_index_o == 4'h1;
  endproperty
  a_bit_first: assert property (p_bit_first) else $error("lowest select lost priority"); // RL18
  property p_bin_path;
    (ms_mode == MS_BINARY) |=> speed_index_o == $past(settled_idx);
  endproperty
  a_bin_path: assert property (p_bin_path) else $error("binary index bypassed settle"); // RL13
  property p_freq_limit;
    ##1 speed_freq_o == '0 || speed_freq_o <= $past(max_freq) || speed_freq_o == $past(start_freq);
  endproperty
  a_freq_limit: assert property (p_freq_limit) else $error("speed frequency above maximum"); // RL15
  property p_no_reverse;
    (ctrl_cfg[CTRL_FSRC_LSB +: 2] != FSRC_TERMINAL) |=> !direction_reverse_o;
  endproperty
  a_no_reverse: assert property (p_no_reverse) else $error("reversal without terminal source"); // RL16
  property p_home_gate;
    !ctrl_cfg[CTRL_ABSPOS_BIT] |=> !home_limit_in_o && !home_trigger_in_o;
  endproperty
  a_home_gate: assert property (p_home_gate) else $error("homing input outside position mode"); // RL4
  property p_fwd_inhibit;
    ##1 fwd_drive_inhibit_o == $past(fn_active(FN_FWD_INHIBIT, func_cfg, level));
  endproperty
  a_fwd_inhibit: assert property (p_fwd_inhibit) else $error("forward inhibit wrong"); // RL5
  property p_bresp_hold;
    (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
endmodule

// file: hw/select_settle.sv
// Purpose: holds back a new binary speed index until it has stayed stable
// Assumes: delay counted in clock_i cycles
// Notes: a delay of zero still costs two cycles from input change to output
`timescale 1ns/1ps
module select_settle #(
  parameter int IDX_W = 4,
  parameter int SETTLE_W = 16
) (
  // system
  input wire logic clock_i,
  input wire logic reset_i,
  // index in and settle time
  input wire logic [IDX_W-1:0] sample_i,
  input wire logic [SETTLE_W-1:0] delay_i,
  // accepted index
  output logic [IDX_W-1:0] settled_o
);
  logic [IDX_W-1:0] last;
  logic [SETTLE_W-1:0] count;
  logic [IDX_W-1:0] next_last;
  logic [SETTLE_W-1:0] next_count;
  logic [IDX_W-1:0] next_settled;

  always_comb begin
    next_last = sample_i;
    next_count = count;
    next_settled = settled_o;
    if (sample_i != last) begin
      next_count = '0;
    end else if (count < delay_i) begin
      next_count = count + SETTLE_W'(1);
    end else begin
      next_settled = last;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      last <= '0;
      count <= '0;
      settled_o <= '0;
    end else begin
      last <= next_last;
      count <= next_count;
      settled_o <= next_settled;
    end
  end

  property p_settle_stable;
    @(posedge clock_i) disable iff (reset_i)
    (settled_o != $past(settled_o)) |-> (settled_o == $past(last) && $past(sample_i) == $past(last));
  endproperty
  a_settle_stable: assert property (p_settle_stable) else $error("index accepted while unstable"); // RL19
endmodule

// file: include/term_decode_pkg.sv
// Purpose: shared constants for the input terminal function decoder
// Assumes: AXI4-Lite with 32-bit data and byte addresses
// Notes: function codes are the documented decimal values written in hex
package term_decode_pkg;
  localparam int NUM_TERM = 8;
  localparam int NUM_SPEED = 16;
  localparam int NUM_ONEHOT = 7;
  localparam int FREQ_W = 16;
  localparam int ADDR_W = 8;

  // terminal function codes
  localparam logic [7:0] FN_BIN_SEL0 = 8'h02;
  localparam logic [7:0] FN_FAULT_RESET = 8'h12;
  localparam logic [7:0] FN_ONEHOT_SEL1 = 8'h20;
  localparam logic [7:0] FN_FORCE_TERM = 8'h33;
  localparam logic [7:0] FN_TORQUE_PERMIT = 8'h34;
  localparam logic [7:0] FN_ENERGY_CLEAR = 8'h35;
  localparam logic [7:0] FN_USER_SEQ1 = 8'h38;
  localparam logic [7:0] FN_ANALOG_HOLD = 8'h41;
  localparam logic [7:0] FN_POS_SEL0 = 8'h42;
  localparam logic [7:0] FN_HOME_LIMIT = 8'h45;
  localparam logic [7:0] FN_HOME_TRIGGER = 8'h46;
  localparam logic [7:0] FN_FWD_INHIBIT = 8'h47;
  localparam logic [7:0] FN_REV_INHIBIT = 8'h48;
  localparam logic [7:0] FN_SPEED_POS = 8'h49;
  localparam logic [7:0] FN_COUNT_PULSE = 8'h4a;
  localparam logic [7:0] FN_COUNT_CLEAR = 8'h4b;

  // setting encodings
  localparam logic [1:0] MS_BINARY = 2'h0;
  localparam logic [1:0] MS_BIT = 2'h1;
  localparam logic [1:0] POL_NC = 2'h1;
  localparam logic [1:0] FSRC_TERMINAL = 2'h1;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_POL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FUNC_LO = 8'h08;
  localparam logic [ADDR_W-1:0] REG_FUNC_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_SETTLE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_LIMITS = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_SPEED_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] REG_SPEED_LAST = 8'h7c;

  // field layout
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FSRC_LSB = 4;
  localparam int CTRL_REVERSIBLE_BIT = 8;
  localparam int CTRL_ABSPOS_BIT = 9;
  localparam int LIM_MAX_LSB = 16;
  localparam int STAT_INDEX_LSB = 12;
  localparam int STAT_REVERSE_BIT = 16;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0333;
  localparam logic [31:0] POL_MASK = 32'h0003_ffff;
  localparam logic [31:0] SETTLE_MASK = 32'h0000_ffff;
  localparam logic [31:0] SPEED_MASK = 32'h0000_ffff;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] POL_RST = 32'h0000_0000;
  localparam logic [63:0] FUNC_RST = 64'h0000_0000_0000_0000;
  localparam logic [31:0] SETTLE_RST = 32'h0000_0000;
  localparam logic [31:0] LIMITS_RST = 32'hffff_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: test/contact_bank.sv
// Purpose: relay contact bank that stands in front of the terminal pins
// Assumes: a commanded contact settles by the next clock edge
// Notes: contacts are bounce-free, so glitches come only from the bench
`timescale 1ns/1ps
module contact_bank (
  // system
  input wire logic clock_i,
  // commanded contacts, 1 = closed, bit 8 is the forward terminal
  input wire logic [8:0] close_i,
  // terminal levels
  output logic [7:0] terminal_o,
  output logic forward_terminal_o
);
  // changes on the edge, like a controller output synchronised to ours
  always_ff @(posedge clock_i) begin
    terminal_o <= close_i[7:0];
    forward_terminal_o <= close_i[8];
  end
endmodule

// file: test/tb_input_terminal_function_decoder.sv
// Purpose: self-checking bench for the input terminal function decoder
// Assumes: registers over axi4-lite, terminals through contact_bank
// Notes: settle delay kept short so binary selection shows quickly
`timescale 1ns/1ps
module tb_input_terminal_function_decoder;
  import term_decode_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [8:0] close = '0;
  logic [7:0] terminal_i, user_seq_input_o;
  logic forward_terminal_i;
  logic signed [FREQ_W-1:0] aux_freq_i = '0;
  logic [2:0] pos_select_o;
  logic count_pulse_in_o, count_clear_in_o, speed_position_switch_o, home_limit_in_o, home_trigger_in_o;
  logic fwd_drive_inhibit_o, rev_drive_inhibit_o, analog_cmd_hold_o, energy_total_clear_o;
  logic torque_cmd_permit_o, force_terminal_op_o, fault_reset_in_o, forward_run_in_o, direction_reverse_o;
  logic [3:0] speed_index_o;
  logic [FREQ_W-1:0] speed_freq_o;
  logic [22:0] fv;
  logic [31:0] got;
  int miscompares = 0;
  int check_count = 0;
  // one code per function output, in the bit order of fv
  logic [7:0] codes [23] = '{8'h33, 8'h34, 8'h35, 8'h41, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h12, 8'h45,
    8'h46, 8'h44, 8'h43, 8'h42, 8'h3f, 8'h3e, 8'h3d, 8'h3c, 8'h3b, 8'h3a, 8'h39, 8'h38};
  assign fv = {force_terminal_op_o, torque_cmd_permit_o, energy_total_clear_o, analog_cmd_hold_o,
    fwd_drive_inhibit_o, rev_drive_inhibit_o, speed_position_switch_o, count_pulse_in_o, count_clear_in_o,
    fault_reset_in_o, home_limit_in_o, home_trigger_in_o, pos_select_o, user_seq_input_o};
  input_terminal_function_decoder u_dut (.clock_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .terminal_i, .forward_terminal_i, .aux_freq_i, .user_seq_input_o,
    .count_pulse_in_o, .count_clear_in_o, .pos_select_o, .speed_position_switch_o, .home_limit_in_o,
    .home_trigger_in_o, .fwd_drive_inhibit_o, .rev_drive_inhibit_o, .analog_cmd_hold_o, .energy_total_clear_o,
    .torque_cmd_permit_o, .force_terminal_op_o, .fault_reset_in_o, .forward_run_in_o, .speed_index_o,
    .speed_freq_o, .direction_reverse_o);
  contact_bank u_contacts (.clock_i(clock_i), .close_i(close), .terminal_o(terminal_i),
    .forward_terminal_o(forward_terminal_i));
  initial forever #2.5 clock_i = ~clock_i;
  task automatic final_report();
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // sampled at the falling edge, so the rising edge that follows is the handshake
  task automatic await(input int k);
    int n;
    n = 0;
    @(negedge clock_i);
    while (!(k == 0 ? s_axi_awready_o : k == 1 ? s_axi_bvalid_o : k == 2 ? s_axi_arready_o : s_axi_rvalid_o)) begin
      n++;
      if (n > 100) begin
        cmp(n, 0);
        final_report();
      end
      @(negedge clock_i);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    await(0);
    @(posedge clock_i);
    s_axi_awvalid_i <= 1'b0;
    s_axi_wvalid_i <= 1'b0;
    await(1);
    resp = s_axi_bresp_o;
    @(posedge clock_i);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    await(2);
    @(posedge clock_i);
    s_axi_arvalid_i <= 1'b0;
    await(3);
    got = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    @(posedge clock_i);
    s_axi_rready_i <= 1'b0;
  endtask
  task automatic pins(input logic [8:0] c, input int n);
    @(posedge clock_i);
    close <= c;
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic s_regs();
    rd(REG_LIMITS);
    cmp(got, LIMITS_RST);
    cmp(resp, RESP_OKAY);
    wr(REG_CTRL, 32'hffff_ffff);
    rd(REG_CTRL);
    cmp(got, CTRL_MASK);
    wr(REG_CTRL, 32'h0);
    rd(8'h20);
    cmp(got, 32'h0);
    cmp(resp, RESP_SLVERR);
    wr(8'h1c, 32'h1);
    cmp(resp, RESP_SLVERR);
  endtask
  task automatic s_func();
    wr(REG_CTRL, 32'h200);
    for (int i = 0; i < 23; i++) begin
      wr(REG_FUNC_LO, {24'h0, codes[i]});
      pins(9'h001, 3);
      cmp(fv, 32'h1 << (22 - i));
      pins(9'h000, 3);
      cmp(fv, 32'h0);
    end
    wr(REG_CTRL, 32'h0);
    wr(REG_FUNC_LO, 32'h4645);
    pins(9'h003, 3);
    cmp({home_limit_in_o, home_trigger_in_o}, 2'b00);
  endtask
  task automatic s_pol();
    wr(REG_FUNC_LO, 32'h33);
    wr(REG_POL, 32'h0001_0001);
    pins(9'h000, 3);
    cmp({force_terminal_op_o, forward_run_in_o}, 2'b11);
    rd(REG_STATUS);
    cmp(got[8:0], 9'h101);
    pins(9'h101, 3);
    cmp({force_terminal_op_o, forward_run_in_o}, 2'b00);
    wr(REG_FUNC_LO, 32'h12);
    pins(9'h000, 3);
    cmp(fault_reset_in_o, 1'b0);
    pins(9'h001, 3);
    cmp(fault_reset_in_o, 1'b1);
    wr(REG_POL, 32'h0);
  endtask
  task automatic s_bin();
    logic [3:0] vals [4] = '{4'h1, 4'h8, 4'hf, 4'h6};
    logic [3:0] old;
    int n;
    old = 4'h0;
    pins(9'h000, 1);
    wr(REG_FUNC_LO, 32'h0504_0302);
    wr(REG_SETTLE, 32'h8);
    for (int i = 0; i < 16; i++) begin
      wr(REG_SPEED_BASE + 8'(4 * i), 32'h100 + i);
    end
    for (int i = 0; i < 4; i++) begin
      pins({5'h0, vals[i]}, 3);
      cmp(speed_index_o, old);
      n = 0;
      while (speed_index_o !== vals[i] && n < 30) begin
        @(negedge clock_i);
        n++;
      end
      cmp(n, 8 + 2);
      cmp(speed_index_o, vals[i]);
      cmp(speed_freq_o, 16'h100 + vals[i]);
      if (n >= 30) begin
        final_report();
      end
      old = vals[i];
    end
    // a burst shorter than the settle time must not be taken
    pins(9'h003, 2);
    pins({5'h0, old}, 3);
    cmp(speed_index_o, old);
  endtask
  task automatic s_bit();
    wr(REG_CTRL, 32'h1);
    wr(REG_FUNC_LO, 32'h2322_2120);
    wr(REG_FUNC_HI, 32'h0026_2524);
    pins(9'h064, 3);
    cmp(speed_index_o, 4'h3);
    pins(9'h040, 3);
    cmp(speed_index_o, 4'h7);
    wr(REG_LIMITS, 32'h0108_0104);
    wr(8'h40, 32'h0);
    wr(8'h44, 32'h101);
    wr(8'h48, 32'h10f);
    pins(9'h000, 3);
    cmp({speed_index_o, speed_freq_o}, 20'h0_0000);
    pins(9'h001, 3);
    cmp(speed_freq_o, 16'h104);
    pins(9'h002, 3);
    cmp(speed_freq_o, 16'h108);
    wr(REG_CTRL, 32'h111);
    aux_freq_i <= -16'sh0200;
    pins(9'h040, 3);
    cmp(direction_reverse_o, 1'b1);
    aux_freq_i <= -16'sh0100;
    pins(9'h040, 3);
    cmp(direction_reverse_o, 1'b0);
    wr(REG_CTRL, 32'h011);
    aux_freq_i <= -16'sh0200;
    pins(9'h040, 3);
    cmp(direction_reverse_o, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    s_regs();
    s_func();
    s_pol();
    s_bin();
    s_bit();
    final_report();
  end
endmodule
